// ==== rtl/lcs_regs.svh ====
// Purpose: Offsets, field positions, reset values and codes of the link control block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Definitions only.
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH
`define LCS_IDX_LINK_CTRL 8'h44
`define LCS_IDX_WIDTH_CFG 8'h46
`define LCS_IDX_IRQ_STAT 8'h50
`define LCS_IDX_IRQ_MASK 8'h51
`define LCS_BIT_PROTO 12
`define LCS_BIT_CRC_LO 8
`define LCS_BIT_TX_OFF 7
`define LCS_BIT_EOC 6
`define LCS_BIT_INIT 5
`define LCS_BIT_FAIL 4
`define LCS_BIT_FORCE 3
`define LCS_BIT_TEST 2
`define LCS_BIT_FLOOD 1
`define LCS_BIT_DW_OUT 15
`define LCS_BIT_WIDTH_LO 12
`define LCS_BIT_DW_IN 11
`define LCS_W_2 3'h4
`define LCS_W_4 3'h5
`define LCS_W_8 3'h0
`define LCS_W_16 3'h1
`define LCS_W_32 3'h3
`define LCS_RST_WIDTH 3'h0
`define LCS_RST_MASK 5'h00
`define LCS_IRQ_PROTO 0
`define LCS_IRQ_CRC 1
`define LCS_IRQ_FAIL 2
`define LCS_IRQ_TEST 3
`define LCS_IRQ_FLOOD 4
`endif

// ==== rtl/lcs_pkg.sv ====
// Purpose: Types shared by the link control block.
// Assumes: Nothing beyond the register header.
// Notes: Mode codes follow the two strap pins.
package lcs_pkg;
   typedef enum logic [1:0] {
      LCS_SP = 2'h0,
      LCS_DSP = 2'h1,
      LCS_GSP = 2'h2,
      LCS_GDP = 2'h3
   } lcs_mode_e;
   // Events and status coming from the link side; events are sampled on link clock edges, init_done is read as a level.
   typedef struct packed {
      logic proto_err;
      logic [3:0] crc_err;
      logic fail_det;
      logic init_done;
      logic neg_done;
      logic [2:0] neg_width;
      logic test_done;
   } lcs_link_in_s;
   // Controls driven toward the link.
   typedef struct packed {
      logic tx_off;
      logic force_crc;
      logic test_run;
      logic sync_flood;
      logic link_fail;
      logic [2:0] width_out;
   } lcs_link_out_s;
endpackage : lcs_pkg

// ==== rtl/lcs_link_ctrl.sv ====
// Purpose: Control and status fields of one packet link port, reached over APB.
// Assumes: Link inputs are asynchronous; events are sampled on rising edges of LINK_CLK, init_done is read as a level;
//          WARM_RST_B and MODE are asynchronous pins; RST_B is the cold reset.
// Notes: APB answers with one wait state; unmapped addresses give PSLVERR.
// Notes on behaviour
// - Protocol error latches, write-one clears, survives warm
// - General modes: bit twelve reads zero
// - Four per-lane CRC error flags, write-one clear
// - Transmit off: set-only, cleared by reset
// - End-of-chain drops packets, nonposted get error
// - End-of-chain set-only, cleared on warm reset
// - Read-only init done status bit
// - Link failure: hardware/software set, software clear
// - Software link failure value applies at warm reset
// - Force bit corrupts outgoing CRC, warm clears
// - CRC test starts on write, self clears
// - Flood enable: CRC error floods, sets failure
// - Outgoing width codes two through eight
// - Width fixed eight in single modes
// - Negotiated width loads; writes apply at warm
// - Doubleword flow control bits read zero
`timescale 1ns/1ps
`include "lcs_regs.svh"
module lcs_link_ctrl (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic WARM_RST_B,
   input wire logic [1:0] MODE,
   input wire logic LINK_CLK,
   input wire lcs_pkg::lcs_link_in_s LINK_IN,
   input wire logic REQ_VALID,
   input wire logic REQ_NONPOSTED,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [9:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output lcs_pkg::lcs_link_out_s LINK_OUT,
   output logic DROP_PKT,
   output logic NXA_RESP,
   output logic IRQ
);
   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers. The first stage of each is read only by the second.
   lcs_pkg::lcs_link_in_s lin_s1_r, lin_s2_r;
   logic [3:0] pin_s1_r, pin_s2_r;
   logic lclk_d_r, mode_cap_r, warm_d_r;
   lcs_pkg::lcs_mode_e mode_r;
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         lin_s1_r <= '0;
         lin_s2_r <= '0;
      end else begin
         lin_s1_r <= LINK_IN;
         lin_s2_r <= lin_s1_r;
      end
   end

   // Pin synchronisers keep running through cold reset, so the mode strap is
   // already settled when it is caught on the first edge after release.
   always_ff @(posedge CLOCK) begin
      pin_s1_r <= {LINK_CLK, WARM_RST_B, MODE};
      pin_s2_r <= pin_s1_r;
   end
   wire logic lclk_s = pin_s2_r[3];
   wire logic warm_b_s = pin_s2_r[2];
   wire logic lclk_rise = lclk_s & ~lclk_d_r;
   wire logic warm_on = ~warm_b_s;
   wire logic warm_end = warm_b_s & ~warm_d_r;

   // Edge history; the mode strap is caught once after cold reset release.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         lclk_d_r <= 1'b0;
         warm_d_r <= 1'b1;
         mode_cap_r <= 1'b0;
         mode_r <= lcs_pkg::LCS_SP;
      end else begin
         lclk_d_r <= lclk_s;
         warm_d_r <= warm_b_s;
         mode_cap_r <= 1'b1;
         if (!mode_cap_r) begin
            mode_r <= lcs_pkg::lcs_mode_e'(pin_s2_r[1:0]);
         end
      end
   end
   wire logic gen_mode = (mode_r == lcs_pkg::LCS_GSP) || (mode_r == lcs_pkg::LCS_GDP);

   // Link events count once per link clock edge, since they are link-cycle levels.
   wire logic ev_proto = lclk_rise & lin_s2_r.proto_err & ~gen_mode;
   wire logic [3:0] ev_crc = {4{lclk_rise}} & lin_s2_r.crc_err;
   wire logic ev_crc_any = |ev_crc;
   wire logic ev_test_done = lclk_rise & lin_s2_r.test_done;
   wire logic ev_neg = lclk_rise & lin_s2_r.neg_done;

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave: the answer comes one cycle into the access phase.
   logic [31:0] rdata_r;
   logic pready_r, pslverr_r;
   wire logic [7:0] idx = PADDR[9:2];
   wire logic acc = PSEL & PENABLE & pready_r;
   wire logic wr = acc & PWRITE;
   function automatic logic hit(input logic [7:0] i, input logic [7:0] want);
      hit = (i == want);
   endfunction : hit
   wire logic wr_ctrl = wr & hit(idx, `LCS_IDX_LINK_CTRL) & ~pslverr_r;
   wire logic wr_wcfg = wr & hit(idx, `LCS_IDX_WIDTH_CFG) & ~pslverr_r;
   wire logic wr_mask = wr & hit(idx, `LCS_IDX_IRQ_MASK) & ~pslverr_r;
   wire logic rd_stat = acc & ~PWRITE & hit(idx, `LCS_IDX_IRQ_STAT);
   wire logic mapped = hit(idx, `LCS_IDX_LINK_CTRL) | hit(idx, `LCS_IDX_WIDTH_CFG)
                      | hit(idx, `LCS_IDX_IRQ_STAT) | hit(idx, `LCS_IDX_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////////
   // Field storage.
   logic proto_r, tx_off_r, eoc_r, fail_r, fail_pend_r, force_r, test_r, flood_en_r;
   logic flood_r;
   logic [3:0] crc_r;
   logic [2:0] width_r, width_pend_r;
   logic [4:0] stat_r, mask_r;

   // Error flags: a hardware set in the clear cycle wins; warm reset keeps them.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         proto_r <= 1'b0;
         crc_r <= 4'h0;
      end else begin
         proto_r <= ev_proto | (proto_r & ~(wr_ctrl & PWDATA[`LCS_BIT_PROTO]));
         crc_r <= ev_crc | (crc_r & ~({4{wr_ctrl}} & PWDATA[`LCS_BIT_CRC_LO +: 4]));
      end
   end

   // Set-only controls; only reset returns them to zero.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         tx_off_r <= 1'b0;
         eoc_r <= 1'b0;
      end else if (warm_on) begin
         tx_off_r <= 1'b0;
         eoc_r <= 1'b0;
      end else begin
         tx_off_r <= tx_off_r | (wr_ctrl & PWDATA[`LCS_BIT_TX_OFF]);
         eoc_r <= eoc_r | (wr_ctrl & PWDATA[`LCS_BIT_EOC]);
      end
   end

   // Test, force and flood controls, all cleared while warm reset is held.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         force_r <= 1'b0;
         test_r <= 1'b0;
         flood_en_r <= 1'b0;
         flood_r <= 1'b0;
      end else if (warm_on) begin
         force_r <= 1'b0;
         test_r <= 1'b0;
         flood_en_r <= 1'b0;
         flood_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            force_r <= PWDATA[`LCS_BIT_FORCE];
            flood_en_r <= PWDATA[`LCS_BIT_FLOOD];
         end
         // A start write in the done cycle restarts the test.
         if (wr_ctrl && PWDATA[`LCS_BIT_TEST]) begin
            test_r <= 1'b1;
         end else if (ev_test_done) begin
            test_r <= 1'b0;
         end
         if (flood_en_r && ev_crc_any) begin
            flood_r <= 1'b1;
         end
      end
   end

   // Link failure: the readable bit changes by hardware, or by the pending
   // software value at the end of warm reset. Keeping both copies lets software
   // stage a recovery without dropping the link under live traffic.
   wire logic hw_fail = (lclk_rise & lin_s2_r.fail_det) | (flood_en_r & ev_crc_any & ~warm_on);
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         fail_r <= 1'b0;
         fail_pend_r <= 1'b0;
      end else begin
         if (hw_fail) begin
            fail_r <= 1'b1;
            fail_pend_r <= 1'b1;
         end else begin
            if (wr_ctrl) begin
               fail_pend_r <= PWDATA[`LCS_BIT_FAIL];
            end
            if (warm_end) begin
               fail_r <= fail_pend_r;
            end
         end
      end
   end

   // Outgoing width: fixed in single modes, negotiated, written values deferred.
   function automatic logic width_ok(input logic [2:0] w);
      width_ok = (w == `LCS_W_2) || (w == `LCS_W_4) || (w == `LCS_W_8);
   endfunction : width_ok
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         width_r <= `LCS_RST_WIDTH;
         width_pend_r <= `LCS_RST_WIDTH;
      end else if (!gen_mode) begin
         width_r <= `LCS_W_8;
         width_pend_r <= `LCS_W_8;
      end else if (ev_neg && width_ok(lin_s2_r.neg_width)) begin
         width_r <= lin_s2_r.neg_width;
         width_pend_r <= lin_s2_r.neg_width;
      end else begin
         if (wr_wcfg && width_ok(PWDATA[`LCS_BIT_WIDTH_LO +: 3])) begin
            width_pend_r <= PWDATA[`LCS_BIT_WIDTH_LO +: 3];
         end
         if (warm_end) begin
            width_r <= width_pend_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky status cleared by its read; a same-cycle event survives.
   wire logic [4:0] ev_vec = {flood_en_r & ev_crc_any, ev_test_done & test_r,
                              hw_fail, ev_crc_any, ev_proto};
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         stat_r <= 5'h00;
         mask_r <= `LCS_RST_MASK;
      end else begin
         stat_r <= ev_vec | (stat_r & ~{5{rd_stat}});
         if (wr_mask) begin
            mask_r <= PWDATA[4:0];
         end
      end
   end

   // Read mux; dword flow control and general-mode bit twelve read zero.
   logic [15:0] ctrl_rd, wcfg_rd;
   always_comb begin
      ctrl_rd = 16'h0000;
      ctrl_rd[`LCS_BIT_PROTO] = proto_r & ~gen_mode;
      ctrl_rd[`LCS_BIT_CRC_LO +: 4] = crc_r;
      ctrl_rd[`LCS_BIT_TX_OFF] = tx_off_r;
      ctrl_rd[`LCS_BIT_EOC] = eoc_r;
      ctrl_rd[`LCS_BIT_INIT] = lin_s2_r.init_done;
      ctrl_rd[`LCS_BIT_FAIL] = fail_r;
      ctrl_rd[`LCS_BIT_FORCE] = force_r;
      ctrl_rd[`LCS_BIT_TEST] = test_r;
      ctrl_rd[`LCS_BIT_FLOOD] = flood_en_r;
      wcfg_rd = 16'h0000;
      wcfg_rd[`LCS_BIT_WIDTH_LO +: 3] = width_r;
   end

   // Answer phase: data and error are registered with PREADY.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         pready_r <= PSEL & PENABLE & ~pready_r;
         pslverr_r <= PSEL & PENABLE & ~pready_r & ~mapped;
         if (PSEL && PENABLE && !pready_r) begin
            case (1'b1)
               hit(idx, `LCS_IDX_LINK_CTRL): rdata_r <= {16'h0000, ctrl_rd};
               hit(idx, `LCS_IDX_WIDTH_CFG): rdata_r <= {16'h0000, wcfg_rd};
               hit(idx, `LCS_IDX_IRQ_STAT): rdata_r <= {27'h0000000, stat_r};
               hit(idx, `LCS_IDX_IRQ_MASK): rdata_r <= {27'h0000000, mask_r};
               default: rdata_r <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link-facing outputs and packet steering, all registered.
   logic drop_r, nxa_r, irq_r;
   lcs_pkg::lcs_link_out_s lout_r;
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         drop_r <= 1'b0;
         nxa_r <= 1'b0;
         irq_r <= 1'b0;
         lout_r <= '0;
      end else begin
         drop_r <= REQ_VALID & eoc_r;
         nxa_r <= REQ_VALID & eoc_r & REQ_NONPOSTED;
         irq_r <= |(stat_r & mask_r);
         lout_r.tx_off <= tx_off_r;
         lout_r.force_crc <= force_r;
         lout_r.test_run <= test_r;
         lout_r.sync_flood <= flood_r;
         lout_r.link_fail <= fail_r;
         lout_r.width_out <= width_r;
      end
   end
   assign PRDATA = rdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign LINK_OUT = lout_r;
   assign DROP_PKT = drop_r;
   assign NXA_RESP = nxa_r;
   assign IRQ = irq_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   sequence ctrl_write(int b);
      wr_ctrl && PWDATA[b];
   endsequence
   sequence done_in_warm;
      warm_on ##1 warm_on;
   endsequence

   proto_latch_a: assert property (ev_proto |=> proto_r)
      else $error("protocol error not latched");
   proto_general_a: assert property (gen_mode && mode_cap_r |-> !ctrl_rd[`LCS_BIT_PROTO])
      else $error("bit twelve nonzero in general mode");
   crc_latch_a: assert property (ev_crc[0] |=> crc_r[0])
      else $error("lane CRC error not latched");
   tx_off_hold_a: assert property (tx_off_r && !warm_on |=> tx_off_r ##1 LINK_OUT.tx_off)
      else $error("transmit off dropped without reset");
   eoc_drop_a: assert property (REQ_VALID && eoc_r && REQ_NONPOSTED |=> DROP_PKT && NXA_RESP)
      else $error("nonposted packet not refused at end of chain");
   eoc_warm_a: assert property (done_in_warm |-> !eoc_r)
      else $error("end of chain survived warm reset");
   fail_defer_a: assert property (ctrl_write(`LCS_BIT_FAIL) && !fail_r && !hw_fail && !warm_end
                                  |=> !fail_r)
      else $error("link failure write took effect early");
   force_warm_a: assert property (done_in_warm |-> !force_r ##1 !LINK_OUT.force_crc)
      else $error("force error survived warm reset");
   test_done_a: assert property (ev_test_done && !wr_ctrl && !warm_on && test_r |=> !test_r)
      else $error("CRC test bit did not self clear");
   flood_a: assert property (flood_en_r && ev_crc_any && !warm_on |=> fail_r ##1 LINK_OUT.sync_flood)
      else $error("CRC error did not flood");
   width_fixed_a: assert property (mode_cap_r && !gen_mode |=> width_r == `LCS_W_8)
      else $error("width not eight in single mode");
   width_defer_a: assert property (gen_mode && !warm_end && !ev_neg |=> $stable(width_r))
      else $error("width changed outside warm reset");
   dword_zero_a: assert property (wcfg_rd[`LCS_BIT_DW_OUT] == 1'b0 && !wcfg_rd[`LCS_BIT_DW_IN])
      else $error("dword flow control bit nonzero");
   set_wins_a: assert property (ev_proto && wr_ctrl && PWDATA[`LCS_BIT_PROTO] |=> proto_r)
      else $error("clear beat hardware set");
endmodule : lcs_link_ctrl

// ==== verif/lcs_peer.sv ====
// Purpose: Peer link model that sends one framed group of link events on request.
// Assumes: The link clock runs only inside a frame, with a period of 80 ns.
// Notes: Between frames the event lines show the inverse of the last frame.
`timescale 1ns/1ps
module lcs_peer (
   input wire logic GO,
   input wire lcs_pkg::lcs_link_in_s FRAME,
   output logic LINK_CLK,
   output lcs_pkg::lcs_link_in_s LINK_IN,
   output logic BUSY
);
   // Data leads the clock edge by half a period, so the sampler never races it.
   initial begin
      LINK_CLK = 1'b0;
      LINK_IN = '0;
      BUSY = 1'b0;
      forever begin
         @(posedge GO);
         BUSY = 1'b1;
         LINK_IN = FRAME;
         #40 LINK_CLK = 1'b1;
         #40 LINK_CLK = 1'b0;
         // Stale data is inverted; the init level is a status, so it is kept.
         LINK_IN = ~FRAME;
         LINK_IN.init_done = FRAME.init_done;
         BUSY = 1'b0;
      end
   end
endmodule : lcs_peer

// ==== verif/tb.sv ====
// Purpose: Self-checking bench of the link control fields over APB.
// Assumes: One wait state per APB transfer; link events reach fields in a few cycles.
// Notes: Link events come from the peer model; software actions from APB tasks.
`timescale 1ns/1ps
`include "lcs_regs.svh"
module tb;
   localparam logic [9:0] A_LC = {`LCS_IDX_LINK_CTRL, 2'h0};
   localparam logic [9:0] A_WC = {`LCS_IDX_WIDTH_CFG, 2'h0};
   localparam logic [9:0] A_ST = {`LCS_IDX_IRQ_STAT, 2'h0};
   localparam logic [9:0] A_MK = {`LCS_IDX_IRQ_MASK, 2'h0};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic warm_b = 1'b1;
   logic [1:0] mode = 2'h0;
   logic go = 1'b0;
   logic busy, lclk, prdy, perr, drop, nonexistent_address_error, irq;
   lcs_pkg::lcs_link_in_s frm = '0;
   lcs_pkg::lcs_link_in_s lin;
   lcs_pkg::lcs_link_out_s lout;
   logic req = 1'b0;
   logic np = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [9:0] padr = 10'h0;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, q;
   logic e;
   logic [3:0] m, s;
   logic [2:0] w;
   logic [2:0] codes [5] = '{3'h4, 3'h5, 3'h0, 3'h1, 3'h3};
   int n_fail = 0;
   int total_checks = 0;
   // Free-running block clock at 100 MHz.
   always #5 clk = ~clk;
   lcs_peer i_peer (.GO(go), .FRAME(frm), .LINK_CLK(lclk), .LINK_IN(lin), .BUSY(busy));
   lcs_link_ctrl i_dut (.CLOCK(clk), .RST_B(rst_b), .WARM_RST_B(warm_b), .MODE(mode),
      .LINK_CLK(lclk), .LINK_IN(lin), .REQ_VALID(req), .REQ_NONPOSTED(np), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(prdy), .PSLVERR(perr), .LINK_OUT(lout), .DROP_PKT(drop), .NXA_RESP(nonexistent_address_error),
      .IRQ(irq));
   ////////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   // Compares one value against its expectation.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; the request is held until PREADY is sampled high.
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= wr;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 20);
      q = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
      if (n >= 20) begin
         n_fail++;
         complete_run();
      end
   endtask : apb
   task automatic rd(input logic [9:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   // Sends one link frame and gives the synchronisers time to settle.
   task automatic send(input lcs_pkg::lcs_link_in_s f);
      int n;
      frm <= f;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'b0 && n < 30);
      if (n >= 30) begin
         n_fail++;
         complete_run();
      end
      repeat (8) @(posedge clk);
   endtask : send
   task automatic warm();
      warm_b <= 1'b0;
      repeat (4) @(posedge clk);
      warm_b <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : warm
   task automatic cold(input logic [1:0] md);
      rst_b <= 1'b0;
      mode <= md;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
   endtask : cold
   // One packet toward the link; the drop pulse stands one cycle later.
   task automatic pkt(input logic eoc);
      req <= 1'b1;
      np <= 1'($urandom);
      @(posedge clk);
      req <= 1'b0;
      @(negedge clk);
      chk(drop, eoc);
      chk(nonexistent_address_error, eoc & np);
      @(posedge clk);
   endtask : pkt
   // Width writes are taken only for the codes the general modes support.
   function automatic logic [2:0] wexp(input logic [2:0] c, input logic [2:0] p);
      return (c == 3'h4 || c == 3'h5 || c == 3'h0) ? c : p;
   endfunction : wexp
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      void'($urandom(32'h1e41));
      cold(2'h0);
      rd(A_LC, 32'h0);
      rd(A_WC, 32'h0);
      rd(A_MK, 32'h0);
      apb(1'b1, 10'h3fc, 32'hffff);
      chk(e, 1'b1);
      rd(10'h3fc, 32'h0);
      $display("test reset done");
      apb(1'b1, A_MK, 32'h1f);
      send('{proto_err: 1'b1, default: '0});
      rd(A_LC, 32'h1000);
      chk(irq, 1'b1);
      apb(1'b1, A_LC, 32'h0);
      rd(A_LC, 32'h1000);
      warm();
      rd(A_LC, 32'h1000);
      rd(A_ST, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      apb(1'b1, A_LC, 32'h1000);
      rd(A_LC, 32'h0);
      $display("test proto done");
      m = 4'($urandom) | 4'h1;
      s = 4'($urandom);
      send('{crc_err: m, default: '0});
      rd(A_LC, {20'h0, m, 8'h0});
      apb(1'b1, A_LC, {20'h0, s, 8'h0});
      rd(A_LC, {20'h0, m & ~s, 8'h0});
      apb(1'b1, A_LC, 32'hf00);
      $display("test crc done");
      pkt(1'b0);
      apb(1'b1, A_LC, 32'h40);
      apb(1'b1, A_LC, 32'hc0);
      apb(1'b1, A_LC, 32'h0);
      rd(A_LC, 32'hc0);
      chk(lout.tx_off, 1'b1);
      pkt(1'b1);
      warm();
      rd(A_LC, 32'h0);
      $display("test eoc done");
      send('{init_done: 1'b1, default: '0});
      apb(1'b1, A_LC, 32'h0);
      rd(A_LC, 32'h20);
      send('0);
      rd(A_LC, 32'h0);
      apb(1'b1, A_LC, 32'h10);
      rd(A_LC, 32'h0);
      warm();
      rd(A_LC, 32'h10);
      chk(lout.link_fail, 1'b1);
      apb(1'b1, A_LC, 32'h0);
      rd(A_LC, 32'h10);
      warm();
      rd(A_LC, 32'h0);
      send('{fail_det: 1'b1, default: '0});
      rd(A_LC, 32'h10);
      apb(1'b1, A_LC, 32'h0);
      warm();
      $display("test fail done");
      apb(1'b1, A_LC, 32'ha);
      @(posedge clk);
      chk(lout.force_crc, 1'b1);
      send('{crc_err: 4'h2, default: '0});
      rd(A_LC, 32'h21a);
      chk(lout.sync_flood, 1'b1);
      warm();
      rd(A_LC, 32'h210);
      chk(lout.sync_flood, 1'b0);
      apb(1'b1, A_LC, 32'h200);
      warm();
      apb(1'b1, A_LC, 32'h4);
      rd(A_LC, 32'h4);
      chk(lout.test_run, 1'b1);
      send('{test_done: 1'b1, default: '0});
      rd(A_LC, 32'h0);
      $display("test flood done");
      apb(1'b1, A_WC, 32'h4000);
      warm();
      rd(A_WC, 32'h0);
      cold(2'h2);
      send('{proto_err: 1'b1, default: '0});
      rd(A_LC, 32'h0);
      w = `LCS_RST_WIDTH;
      foreach (codes[i]) begin
         apb(1'b1, A_WC, 32'h8800 | {17'h0, codes[i], 12'h0});
         warm();
         w = wexp(codes[i], w);
         rd(A_WC, {17'h0, w, 12'h0});
         chk(lout.width_out, w);
      end
      send('{neg_done: 1'b1, neg_width: `LCS_W_4, default: '0});
      rd(A_WC, {17'h0, `LCS_W_4, 12'h0});
      $display("test width done");
      complete_run();
   end
endmodule : tb
